// ===== rtl/pfss_pkg.sv
// Constants, encodings and carrier types of the pin function select slice
package pfss_pkg;

  // Pad order inside the packed pad vectors
  localparam int NUM_PADS              = 5;
  localparam int PAD_PORTA_PIN_SEVEN   = 0;
  localparam int PAD_PORTB_PIN_THREE   = 1;
  localparam int PAD_PORTB_PIN_FOUR    = 2;
  localparam int PAD_PORTA_PIN_ZERO    = 3;
  localparam int PAD_PORTA_PIN_ONE     = 4;

  // Pin configuration field width and placement
  localparam int CFG_REG_W             = 16;
  localparam int FLD_W                 = 4;
  localparam int FLD_PORTA_SEVEN_LSB   = 12;
  localparam int FLD_PORTB_THREE_LSB   = 12;
  localparam int FLD_PORTB_FOUR_LSB    = 0;
  localparam int FLD_PORTA_ZERO_LSB    = 0;
  localparam int FLD_PORTA_ONE_LSB     = 4;

  // Pin configuration field encodings
  localparam logic [3:0] CFG_ANALOG    = 4'h0;
  localparam logic [3:0] CFG_OUT       = 4'h1;
  localparam logic [3:0] CFG_IN        = 4'h4;
  localparam logic [3:0] CFG_OUT_OD    = 4'h5;
  localparam logic [3:0] CFG_IN_PULL   = 4'h8;
  localparam logic [3:0] CFG_ALT_OUT   = 4'h9;
  localparam logic [3:0] CFG_ALT_OD    = 4'hd;

  // Control bit positions
  localparam int DBG_REG_DIS_BIT       = 4;
  localparam int REMAP_CH1_BIT         = 4;
  localparam int REMAP_CH3_BIT         = 6;
  localparam int REMAP_CH4_BIT         = 7;
  localparam int SPI_MASTER_BIT        = 4;
  localparam int UART_HANDSHAKE_BIT    = 5;

  // Timer output enable index per channel
  localparam int TMR_EN_W              = 4;
  localparam int CH1_IDX               = 0;
  localparam int CH3_IDX               = 2;
  localparam int CH4_IDX               = 3;

  typedef enum logic [1:0] {
    PFSS_SC_OFF  = 2'b00,
    PFSS_SC_UART = 2'b01,
    PFSS_SC_SPI  = 2'b10,
    PFSS_SC_TWI  = 2'b11
  } pfss_sc_mode_t;

  typedef struct packed {
    logic out;
    logic oe;
  } pfss_pad_t;

  // Values after reset
  localparam pfss_pad_t PAD_RESET      = 2'h0;
  localparam logic      IN_RESET       = 1'h0;
  localparam logic      IN_N_RESET     = 1'h1;

endpackage

// ===== rtl/pfss_pin_select.sv
// Pin function select slice for five general-purpose pads
`timescale 1ns/100ps
// Summary of operation
// R1 - Reset: high-current pin is regulator open-drain enable
// R2 - Timer one ch4 out needs enable, alt, regulator off
// R3 - Timer one ch4 input always from that pin
// R4 - Remap bit 6 picks ch3 pin, output gated
// R5 - Remap bit 7 puts ch4 on port B four
// R6 - Remap bit 4 clear puts ch1 on A zero
// R7 - Serial one SPI master clock out when unclaimed
// R8 - Serial one SPI slave clock in from B three
// R9 - Serial one clear-to-send from B three when handshaking
// R10 - Serial one request-to-send out when unclaimed
// R11 - Serial one slave select from B four
// R12 - Serial two master data out on A zero
// R13 - Serial two slave data in from A zero
// R14 - Serial two two-wire data open-drain on A one
// R15 - Serial two slave data out on A one
// R16 - Serial two master data in from A one
// R17 - Analog field connects USB lines on A zero/one
// R18 - Otherwise pins behave as general-purpose I/O
module pfss_pin_select #(
  parameter bit USB_PRESENT = 1'b1
) (
  input  wire logic                                      clk,
  input  wire logic                                      rst_b,
  input  wire logic [pfss_pkg::CFG_REG_W-1:0]            debug_pin_config,
  input  wire logic [pfss_pkg::CFG_REG_W-1:0]            porta_low_pin_config,
  input  wire logic [pfss_pkg::CFG_REG_W-1:0]            porta_high_pin_config,
  input  wire logic [pfss_pkg::CFG_REG_W-1:0]            portb_low_pin_config,
  input  wire logic [pfss_pkg::CFG_REG_W-1:0]            portb_high_pin_config,
  input  wire logic [pfss_pkg::CFG_REG_W-1:0]            timer_two_remap_option,
  input  wire logic [pfss_pkg::CFG_REG_W-1:0]            serial_one_uart_config,
  input  wire logic [pfss_pkg::CFG_REG_W-1:0]            serial_one_spi_config,
  input  wire logic [pfss_pkg::CFG_REG_W-1:0]            serial_two_spi_config,
  input  wire pfss_pkg::pfss_sc_mode_t                   serial_one_mode_select,
  input  wire pfss_pkg::pfss_sc_mode_t                   serial_two_mode_select,
  input  wire logic [pfss_pkg::TMR_EN_W-1:0]             timer_one_output_enables,
  input  wire logic [pfss_pkg::TMR_EN_W-1:0]             timer_two_output_enables,
  input  wire logic                                      reg_enable_pull_low,
  input  wire logic                                      timer_one_chan_four_out,
  input  wire logic                                      timer_two_chan_one_out,
  input  wire logic                                      timer_two_chan_three_out,
  input  wire logic                                      timer_two_chan_four_out,
  input  wire logic                                      serial_one_spi_clock_out,
  input  wire logic                                      serial_one_request_to_send_n,
  input  wire logic                                      serial_two_master_out,
  input  wire logic                                      serial_two_slave_data_out,
  input  wire logic                                      serial_two_twowire_data_out,
  input  wire logic [pfss_pkg::NUM_PADS-1:0]             gpio_out,
  input  wire logic [pfss_pkg::NUM_PADS-1:0]             pad_in,
  output pfss_pkg::pfss_pad_t [pfss_pkg::NUM_PADS-1:0]   pad_drive_r,
  output logic [pfss_pkg::NUM_PADS-1:0]                  gpio_in_r,
  output logic                                           timer_one_chan_four_in_r,
  output logic                                           timer_two_chan_one_in_r,
  output logic                                           timer_two_chan_three_in_r,
  output logic                                           timer_two_chan_four_in_r,
  output logic                                           serial_one_spi_clock_in_r,
  output logic                                           serial_one_clear_to_send_n_r,
  output logic                                           serial_one_slave_select_n_r,
  output logic                                           serial_two_slave_data_in_r,
  output logic                                           serial_two_master_in_r,
  output logic                                           serial_two_twowire_data_in_r,
  output logic                                           usb_minus_line_r,
  output logic                                           usb_plus_line_r,
  output logic                                           regulator_active_r
);
  logic [pfss_pkg::FLD_W-1:0]           fld [pfss_pkg::NUM_PADS];
  pfss_pkg::pfss_pad_t [pfss_pkg::NUM_PADS-1:0] drive_nxt;
  logic                                 reg_en_on;
  logic                                 ch1_claim;
  logic                                 ch3_at_b3;
  logic                                 ch3_at_a1;
  logic                                 ch4_at_b4;
  logic                                 sc1_uart_hs;
  logic                                 sc1_spi_master;
  logic                                 sc1_spi_slave;
  logic                                 sc2_spi_master;
  logic                                 sc2_spi_slave;
  logic                                 sc2_twi;
  logic                                 usb_minus_nxt;
  logic                                 usb_plus_nxt;
  function automatic logic is_alt(input logic [3:0] f);
    is_alt = (f == pfss_pkg::CFG_ALT_OUT) || (f == pfss_pkg::CFG_ALT_OD);
  endfunction
  // Alternate drive honours the push-pull or open-drain choice of the field
  function automatic pfss_pkg::pfss_pad_t alt_drive(input logic [3:0] f, input logic v);
    pfss_pkg::pfss_pad_t d;
    d.out = (f == pfss_pkg::CFG_ALT_OD) ? 1'b0 : v;
    d.oe  = (f == pfss_pkg::CFG_ALT_OD) ? ~v : 1'b1;
    alt_drive = d;
  endfunction
  function automatic pfss_pkg::pfss_pad_t gpio_drive(input logic [3:0] f, input logic v);
    pfss_pkg::pfss_pad_t d;
    d = pfss_pkg::PAD_RESET;
    if (f == pfss_pkg::CFG_OUT)
    begin
      d.out = v;
      d.oe  = 1'b1;
    end
    else if (f == pfss_pkg::CFG_OUT_OD)
    begin
      d.out = 1'b0;
      d.oe  = ~v;
    end
    gpio_drive = d;
  endfunction
  assign fld[pfss_pkg::PAD_PORTA_PIN_SEVEN] =
    porta_high_pin_config[pfss_pkg::FLD_PORTA_SEVEN_LSB +: pfss_pkg::FLD_W];
  assign fld[pfss_pkg::PAD_PORTB_PIN_THREE] =
    portb_low_pin_config[pfss_pkg::FLD_PORTB_THREE_LSB +: pfss_pkg::FLD_W];
  assign fld[pfss_pkg::PAD_PORTB_PIN_FOUR]  =
    portb_high_pin_config[pfss_pkg::FLD_PORTB_FOUR_LSB +: pfss_pkg::FLD_W];
  assign fld[pfss_pkg::PAD_PORTA_PIN_ZERO]  =
    porta_low_pin_config[pfss_pkg::FLD_PORTA_ZERO_LSB +: pfss_pkg::FLD_W];
  assign fld[pfss_pkg::PAD_PORTA_PIN_ONE]   =
    porta_low_pin_config[pfss_pkg::FLD_PORTA_ONE_LSB +: pfss_pkg::FLD_W];
  // Claims and serial modes
  assign reg_en_on      = ~debug_pin_config[pfss_pkg::DBG_REG_DIS_BIT]; // see R1
  assign ch1_claim      = ~timer_two_remap_option[pfss_pkg::REMAP_CH1_BIT]
                          & timer_two_output_enables[pfss_pkg::CH1_IDX];   // see R6
  assign ch3_at_b3      = timer_two_remap_option[pfss_pkg::REMAP_CH3_BIT]
                          & timer_two_output_enables[pfss_pkg::CH3_IDX];   // see R4
  assign ch3_at_a1      = ~timer_two_remap_option[pfss_pkg::REMAP_CH3_BIT]
                          & timer_two_output_enables[pfss_pkg::CH3_IDX];   // see R4
  assign ch4_at_b4      = timer_two_remap_option[pfss_pkg::REMAP_CH4_BIT]
                          & timer_two_output_enables[pfss_pkg::CH4_IDX];   // see R5
  assign sc1_uart_hs    = (serial_one_mode_select == pfss_pkg::PFSS_SC_UART)
                          & serial_one_uart_config[pfss_pkg::UART_HANDSHAKE_BIT];
  assign sc1_spi_master = (serial_one_mode_select == pfss_pkg::PFSS_SC_SPI)
                          & serial_one_spi_config[pfss_pkg::SPI_MASTER_BIT];
  assign sc1_spi_slave  = (serial_one_mode_select == pfss_pkg::PFSS_SC_SPI)
                          & ~serial_one_spi_config[pfss_pkg::SPI_MASTER_BIT];
  assign sc2_spi_master = (serial_two_mode_select == pfss_pkg::PFSS_SC_SPI)
                          & serial_two_spi_config[pfss_pkg::SPI_MASTER_BIT];
  assign sc2_spi_slave  = (serial_two_mode_select == pfss_pkg::PFSS_SC_SPI)
                          & ~serial_two_spi_config[pfss_pkg::SPI_MASTER_BIT];
  assign sc2_twi        = (serial_two_mode_select == pfss_pkg::PFSS_SC_TWI);
  // Output source selection, regulator enable first, then timers, then serial, then plain I/O
  always_comb
  begin
    for (int i = 0; i < pfss_pkg::NUM_PADS; i++)
    begin
      drive_nxt[i] = gpio_drive(fld[i], gpio_out[i]); // see R18
    end
    usb_minus_nxt = 1'b0;
    usb_plus_nxt  = 1'b0;
    // High-current pin: regulator enable overrides everything
    if (reg_en_on)
    begin
      drive_nxt[pfss_pkg::PAD_PORTA_PIN_SEVEN].out = 1'b0; // see R1
      drive_nxt[pfss_pkg::PAD_PORTA_PIN_SEVEN].oe  = reg_enable_pull_low; // see R1
    end
    else if (timer_one_output_enables[pfss_pkg::CH4_IDX]
             && is_alt(fld[pfss_pkg::PAD_PORTA_PIN_SEVEN]))
    begin
      drive_nxt[pfss_pkg::PAD_PORTA_PIN_SEVEN] =
        alt_drive(fld[pfss_pkg::PAD_PORTA_PIN_SEVEN], timer_one_chan_four_out); // see R2
    end
    if (is_alt(fld[pfss_pkg::PAD_PORTB_PIN_THREE]))
    begin
      if (ch3_at_b3)
      begin
        drive_nxt[pfss_pkg::PAD_PORTB_PIN_THREE] =
          alt_drive(fld[pfss_pkg::PAD_PORTB_PIN_THREE], timer_two_chan_three_out); // see R4
      end
      else if (sc1_spi_master)
      begin
        drive_nxt[pfss_pkg::PAD_PORTB_PIN_THREE] =
          alt_drive(fld[pfss_pkg::PAD_PORTB_PIN_THREE], serial_one_spi_clock_out); // see R7
      end
    end
    if (is_alt(fld[pfss_pkg::PAD_PORTB_PIN_FOUR]))
    begin
      if (ch4_at_b4)
      begin
        drive_nxt[pfss_pkg::PAD_PORTB_PIN_FOUR] =
          alt_drive(fld[pfss_pkg::PAD_PORTB_PIN_FOUR], timer_two_chan_four_out); // see R5
      end
      else if (sc1_uart_hs)
      begin
        drive_nxt[pfss_pkg::PAD_PORTB_PIN_FOUR] =
          alt_drive(fld[pfss_pkg::PAD_PORTB_PIN_FOUR], serial_one_request_to_send_n); // see R10
      end
    end
    // Analog selection releases the pad; USB lines attach where fitted
    if (fld[pfss_pkg::PAD_PORTA_PIN_ZERO] == pfss_pkg::CFG_ANALOG)
    begin
      usb_minus_nxt = USB_PRESENT; // see R17
    end
    else if (is_alt(fld[pfss_pkg::PAD_PORTA_PIN_ZERO]))
    begin
      if (ch1_claim)
      begin
        drive_nxt[pfss_pkg::PAD_PORTA_PIN_ZERO] =
          alt_drive(fld[pfss_pkg::PAD_PORTA_PIN_ZERO], timer_two_chan_one_out); // see R6
      end
      else if (sc2_spi_master)
      begin
        drive_nxt[pfss_pkg::PAD_PORTA_PIN_ZERO] =
          alt_drive(fld[pfss_pkg::PAD_PORTA_PIN_ZERO], serial_two_master_out); // see R12
      end
    end
    if (fld[pfss_pkg::PAD_PORTA_PIN_ONE] == pfss_pkg::CFG_ANALOG)
    begin
      usb_plus_nxt = USB_PRESENT; // see R17
    end
    else if (is_alt(fld[pfss_pkg::PAD_PORTA_PIN_ONE]))
    begin
      if (ch3_at_a1)
      begin
        drive_nxt[pfss_pkg::PAD_PORTA_PIN_ONE] =
          alt_drive(fld[pfss_pkg::PAD_PORTA_PIN_ONE], timer_two_chan_three_out); // see R4
      end
      else if (sc2_twi && fld[pfss_pkg::PAD_PORTA_PIN_ONE] == pfss_pkg::CFG_ALT_OD)
      begin
        drive_nxt[pfss_pkg::PAD_PORTA_PIN_ONE].out = 1'b0; // see R14
        drive_nxt[pfss_pkg::PAD_PORTA_PIN_ONE].oe  = ~serial_two_twowire_data_out; // see R14
      end
      else if (sc2_spi_slave)
      begin
        drive_nxt[pfss_pkg::PAD_PORTA_PIN_ONE] =
          alt_drive(fld[pfss_pkg::PAD_PORTA_PIN_ONE], serial_two_slave_data_out); // see R15
      end
    end
  end
  // Pad drive and general-purpose input per pad
  for (genvar g = 0; g < pfss_pkg::NUM_PADS; g++)
  begin : g_pad
    always_ff @(posedge clk or negedge rst_b)
    begin
      if (!rst_b)
      begin
        pad_drive_r[g] <= pfss_pkg::PAD_RESET;
        gpio_in_r[g]   <= pfss_pkg::IN_RESET;
      end
      else
      begin
        pad_drive_r[g] <= drive_nxt[g];
        // Analog pads keep their digital input quiet
        gpio_in_r[g]   <= (fld[g] == pfss_pkg::CFG_ANALOG) ? 1'b0 : pad_in[g]; // see R18
      end
    end
  end
  // Timer inputs
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      timer_one_chan_four_in_r  <= pfss_pkg::IN_RESET;
      timer_two_chan_one_in_r   <= pfss_pkg::IN_RESET;
      timer_two_chan_three_in_r <= pfss_pkg::IN_RESET;
      timer_two_chan_four_in_r  <= pfss_pkg::IN_RESET;
    end
    else
    begin
      timer_one_chan_four_in_r  <= pad_in[pfss_pkg::PAD_PORTA_PIN_SEVEN]; // see R3
      timer_two_chan_one_in_r   <= timer_two_remap_option[pfss_pkg::REMAP_CH1_BIT] ?
                                   1'b0 : pad_in[pfss_pkg::PAD_PORTA_PIN_ZERO]; // see R6
      timer_two_chan_three_in_r <= timer_two_remap_option[pfss_pkg::REMAP_CH3_BIT] ?
                                   pad_in[pfss_pkg::PAD_PORTB_PIN_THREE] :
                                   pad_in[pfss_pkg::PAD_PORTA_PIN_ONE]; // see R4
      timer_two_chan_four_in_r  <= timer_two_remap_option[pfss_pkg::REMAP_CH4_BIT] ?
                                   pad_in[pfss_pkg::PAD_PORTB_PIN_FOUR] : 1'b0; // see R5
    end
  end
  // Serial inputs; unselected active-low inputs rest inactive
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      serial_one_spi_clock_in_r    <= pfss_pkg::IN_RESET;
      serial_one_clear_to_send_n_r <= pfss_pkg::IN_N_RESET;
      serial_one_slave_select_n_r  <= pfss_pkg::IN_N_RESET;
      serial_two_slave_data_in_r   <= pfss_pkg::IN_RESET;
      serial_two_master_in_r       <= pfss_pkg::IN_RESET;
      serial_two_twowire_data_in_r <= pfss_pkg::IN_N_RESET;
    end
    else
    begin
      serial_one_spi_clock_in_r    <= sc1_spi_slave &
                                      pad_in[pfss_pkg::PAD_PORTB_PIN_THREE]; // see R8
      serial_one_clear_to_send_n_r <= sc1_uart_hs ?
                                      pad_in[pfss_pkg::PAD_PORTB_PIN_THREE] : 1'b1; // see R9
      serial_one_slave_select_n_r  <= sc1_spi_slave ?
                                      pad_in[pfss_pkg::PAD_PORTB_PIN_FOUR] : 1'b1; // see R11
      serial_two_slave_data_in_r   <= sc2_spi_slave &
                                      pad_in[pfss_pkg::PAD_PORTA_PIN_ZERO]; // see R13
      serial_two_master_in_r       <= sc2_spi_master &
                                      pad_in[pfss_pkg::PAD_PORTA_PIN_ONE]; // see R16
      serial_two_twowire_data_in_r <= sc2_twi ?
                                      pad_in[pfss_pkg::PAD_PORTA_PIN_ONE] : 1'b1; // see R14
    end
  end
  // Analog and regulator status
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      usb_minus_line_r   <= 1'b0;
      usb_plus_line_r    <= 1'b0;
      regulator_active_r <= 1'b1;
    end
    else
    begin
      usb_minus_line_r   <= usb_minus_nxt;
      usb_plus_line_r    <= usb_plus_nxt;
      regulator_active_r <= reg_en_on; // see R1
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  reg_enable_pin_a: assert property (reg_en_on |=> // see R1
    !pad_drive_r[0].out && pad_drive_r[0].oe == $past(reg_enable_pull_low) && regulator_active_r)
    else $error("regulator enable not driving its pin");
  timer_one_out_a: assert property (!reg_en_on && timer_one_output_enables[3] // see R2
    && fld[0] == pfss_pkg::CFG_ALT_OUT |=> pad_drive_r[0] == {$past(timer_one_chan_four_out), 1'b1})
    else $error("timer one channel four output not on pin");
  timer_one_in_a: assert property (##1 timer_one_chan_four_in_r == $past(pad_in[0])) // see R3
    else $error("timer one channel four input not from pin");
  ch3_remap_in_a: assert property (timer_two_remap_option[6] // see R4
    |=> timer_two_chan_three_in_r == $past(pad_in[1]))
    else $error("remapped channel three input wrong");
  ch4_remap_out_a: assert property (ch4_at_b4 && fld[2] == pfss_pkg::CFG_ALT_OUT // see R5
    |=> pad_drive_r[2].out == $past(timer_two_chan_four_out) && pad_drive_r[2].oe)
    else $error("channel four output not on port B four");
  ch1_in_a: assert property (timer_two_remap_option[4] |=> !timer_two_chan_one_in_r) // see R6
    else $error("channel one input taken while remapped");
  sc1_clk_out_a: assert property (ch3_at_b3 |=> // see R7
    $past(fld[1]) != pfss_pkg::CFG_ALT_OUT || pad_drive_r[1].out == $past(timer_two_chan_three_out))
    else $error("serial clock took a claimed pin");
  sc1_clk_in_a: assert property (!sc1_spi_slave |=> !serial_one_spi_clock_in_r) // see R8
    else $error("slave clock passed outside slave mode");
  sc1_cts_a: assert property (sc1_uart_hs ##1 1 |-> // see R9
    serial_one_clear_to_send_n_r == $past(pad_in[1]))
    else $error("clear to send not from port B three");
  sc1_rts_a: assert property (!ch4_at_b4 && sc1_uart_hs && fld[2] == pfss_pkg::CFG_ALT_OUT // see R10
    |=> pad_drive_r[2] == {$past(serial_one_request_to_send_n), 1'b1})
    else $error("request to send not driven");
  sc1_ssel_a: assert property (!sc1_spi_slave |=> serial_one_slave_select_n_r) // see R11
    else $error("slave select active outside slave mode");
  sc2_mosi_a: assert property (!ch1_claim && sc2_spi_master && fld[3] == pfss_pkg::CFG_ALT_OUT // see R12
    |=> pad_drive_r[3].out == $past(serial_two_master_out))
    else $error("master data out missing");
  sc2_sdi_a: assert property (sc2_spi_slave |=> serial_two_slave_data_in_r == $past(pad_in[3])) // see R13
    else $error("slave data in not from port A zero");
  sc2_sda_a: assert property (!ch3_at_a1 && sc2_twi && fld[4] == pfss_pkg::CFG_ALT_OD // see R14
    |=> !pad_drive_r[4].out && pad_drive_r[4].oe == !$past(serial_two_twowire_data_out))
    else $error("two-wire data not open-drain");
  sc2_miso_a: assert property (!ch3_at_a1 && sc2_spi_slave && fld[4] == pfss_pkg::CFG_ALT_OUT // see R15
    |=> pad_drive_r[4].out == $past(serial_two_slave_data_out))
    else $error("slave data out missing");
  sc2_mdi_a: assert property (sc2_spi_master |=> serial_two_master_in_r == $past(pad_in[4])) // see R16
    else $error("master data in not from port A one");
  usb_attach_a: assert property (fld[3] == pfss_pkg::CFG_ANALOG |=> // see R17
    usb_minus_line_r == USB_PRESENT && !pad_drive_r[3].oe && !gpio_in_r[3])
    else $error("analog select did not attach USB line");
  gpio_pp_a: assert property (!ch3_at_a1 && fld[4] == pfss_pkg::CFG_OUT // see R18
    |=> pad_drive_r[4] == {$past(gpio_out[4]), 1'b1})
    else $error("plain output not driven");
  reg_release_c: cover property (reg_en_on ##1 !reg_en_on [*2]);
  twi_use_c:     cover property (sc2_twi && fld[4] == pfss_pkg::CFG_ALT_OD);
  remap_swap_c:  cover property (ch3_at_b3 ##1 ch3_at_a1);
  usb_both_c:    cover property (usb_minus_line_r && usb_plus_line_r);

endmodule // pfss_pin_select

// ===== verification/pfss_pad_model.sv
// Pad-side partner: pad levels seen by the block from its drivers or the outside
`timescale 1ns/100ps
module pfss_pad_model (
  input  wire pfss_pkg::pfss_pad_t [pfss_pkg::NUM_PADS-1:0] pad_drive,
  input  wire logic [pfss_pkg::NUM_PADS-1:0]                 ext_level,
  output logic [pfss_pkg::NUM_PADS-1:0]                      pad_in
);
  // A driven pad shows the block's level, otherwise the outside source wins
  always_comb
    for (int i = 0; i < pfss_pkg::NUM_PADS; i++)
      pad_in[i] = pad_drive[i].oe ? pad_drive[i].out : ext_level[i];
endmodule // pfss_pad_model

// ===== verification/tb_top.sv
// Self-checking bench of the pin function select slice
`timescale 1ns/100ps
module tb_top;
  logic                                  clk, rst_b, rpl, t14, t21, t23, t24, sck, rts, mo, so, tw;
  logic [15:0]                           dbg, pal, pah, pbl, pbh, rmp, u1, s1, s2;
  pfss_pkg::pfss_sc_mode_t               m1, m2;
  logic [3:0]                            e1, e2;
  logic [4:0]                            gpo, ext, pin, gin;
  pfss_pkg::pfss_pad_t [4:0]             pd;
  logic                                  i14, i21, i23, i24, ick, cts, ssl, sli, mi, twi, um, up, ra;
  int                                    error_cnt, checks_done;
  localparam logic [3:0]                 ALT = pfss_pkg::CFG_ALT_OUT;
  localparam logic [3:0]                 INP = pfss_pkg::CFG_IN;

  pfss_pin_select u_pfss_pin_select (.clk(clk), .rst_b(rst_b), .debug_pin_config(dbg),
    .porta_low_pin_config(pal), .porta_high_pin_config(pah), .portb_low_pin_config(pbl),
    .portb_high_pin_config(pbh), .timer_two_remap_option(rmp), .serial_one_uart_config(u1),
    .serial_one_spi_config(s1), .serial_two_spi_config(s2), .serial_one_mode_select(m1),
    .serial_two_mode_select(m2), .timer_one_output_enables(e1), .timer_two_output_enables(e2),
    .reg_enable_pull_low(rpl), .timer_one_chan_four_out(t14), .timer_two_chan_one_out(t21),
    .timer_two_chan_three_out(t23), .timer_two_chan_four_out(t24),
    .serial_one_spi_clock_out(sck), .serial_one_request_to_send_n(rts),
    .serial_two_master_out(mo), .serial_two_slave_data_out(so),
    .serial_two_twowire_data_out(tw), .gpio_out(gpo), .pad_in(pin), .pad_drive_r(pd),
    .gpio_in_r(gin), .timer_one_chan_four_in_r(i14), .timer_two_chan_one_in_r(i21),
    .timer_two_chan_three_in_r(i23), .timer_two_chan_four_in_r(i24),
    .serial_one_spi_clock_in_r(ick), .serial_one_clear_to_send_n_r(cts),
    .serial_one_slave_select_n_r(ssl), .serial_two_slave_data_in_r(sli),
    .serial_two_master_in_r(mi), .serial_two_twowire_data_in_r(twi),
    .usb_minus_line_r(um), .usb_plus_line_r(up), .regulator_active_r(ra));
  pfss_pad_model u_pfss_pad_model (.pad_drive(pd), .ext_level(ext), .pad_in(pin));

  always #2 clk = ~clk;

  task clr;
    {dbg, pal, pah, pbl, pbh, rmp, u1, s1, s2} = '0;
    m1 = pfss_pkg::PFSS_SC_OFF;
    m2 = pfss_pkg::PFSS_SC_OFF;
    {e1, e2, rpl, t14, t21, t23, t24, sck, rts, mo, so, tw, gpo, ext} = '0;
  endtask
  // Two edges: one registers the pad drive, one registers the inputs read back from the pads
  task step;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task chk(input logic [4:0] g, input logic [4:0] e);
    checks_done++;
    if (g !== e)
    begin
      error_cnt++;
      $display("Error %0t: got %b expected %b", $time, g, e);
    end
  endtask
  task done(input string s);
    $display("test %s finished", s);
  endtask
  task end_sim;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    #5000;
    error_cnt++;
    end_sim;
  end

  initial
  begin
    clk = 1'b0; rst_b = 1'b0; error_cnt = 0; checks_done = 0;
    clr;
    repeat (5) @(posedge clk);
    #1;
    chk(ra, 1'b1); chk(pd[0], 2'b00);
    rst_b = 1'b1;
    for (int v = 0; v < 2; v++)
    begin
      clr; rpl = 1'b1; e1[3] = 1'b1; pah[15:12] = ALT; t14 = v[0]; step;
      chk(pd[0], 2'b01); chk(ra, 1'b1);
      dbg[4] = 1'b1; step;
      chk(pd[0], {v[0], 1'b1}); chk(ra, 1'b0);
      pah[15:12] = INP; ext[0] = v[0]; step;
      chk(i14, v[0]); done("regulator");
      clr; rmp[7:6] = 2'b11; e2 = 4'hf; pbl[15:12] = ALT; pbh[3:0] = ALT; pal[3:0] = ALT;
      {t21, t23, t24} = {3{v[0]}}; step;
      chk(pd[1], {v[0], 1'b1}); chk(pd[2], {v[0], 1'b1}); chk(pd[3], {v[0], 1'b1});
      rmp[6] = 1'b0; pal[7:4] = ALT; step;
      chk(pd[4], {v[0], 1'b1});
      rmp[6] = 1'b1; pbl[15:12] = INP; pbh[3:0] = INP; pal[7:0] = 8'h44;
      ext = {~v[0], {4{v[0]}}}; step;
      chk(i23, v[0]); chk(i24, v[0]); chk(i21, v[0]); done("timers");
      clr; m1 = pfss_pkg::PFSS_SC_SPI; m2 = pfss_pkg::PFSS_SC_SPI; s1[4] = 1'b1; s2[4] = 1'b1;
      e2 = 4'h5; rmp[4] = 1'b1; pbl[15:12] = ALT; pal[7:0] = 8'h49;
      {sck, mo, ext[4]} = {3{v[0]}}; step;
      chk(pd[1], {v[0], 1'b1}); chk(pd[3], {v[0], 1'b1}); chk(mi, v[0]);
      s1[4] = 1'b0; s2[4] = 1'b0; e2 = 4'h0; pbl[15:12] = INP; pbh[3:0] = INP; pal[7:0] = 8'h94;
      so = v[0]; ext = {5{v[0]}}; step;
      chk(ick, v[0]); chk(ssl, v[0]); chk(sli, v[0]);
      chk(pd[4], {v[0], 1'b1}); done("spi");
      clr; m1 = pfss_pkg::PFSS_SC_UART; u1[5] = 1'b1; e2[3] = 1'b1; pbl[15:12] = INP;
      pbh[3:0] = ALT; rts = v[0]; ext[1] = v[0]; step;
      chk(pd[2], {v[0], 1'b1}); chk(cts, v[0]); done("uart");
      clr; m2 = pfss_pkg::PFSS_SC_TWI; pal[7:4] = pfss_pkg::CFG_ALT_OD; tw = v[0]; ext[4] = v[0];
      step;
      chk(pd[4], {1'b0, ~v[0]}); chk(twi, v[0]); done("twowire");
      clr; m2 = pfss_pkg::PFSS_SC_SPI; s2[4] = 1'b1; e2 = 4'hf; {mo, t21} = 2'b11; step;
      chk(um, 1'b1); chk(up, 1'b1); chk(pd[3], 2'b00); chk(pd[4], 2'b00);
      clr; dbg[4] = 1'b1; pah[15:12] = 4'h1; pbl[15:12] = 4'h1; pbh[3:0] = 4'h1; pal[7:0] = 8'h11;
      gpo = {5{v[0]}}; step;
      for (int i = 0; i < 5; i++)
        chk(pd[i], {v[0], 1'b1});
      chk({um, up}, 2'b00);
      pah[15:12] = 4'h5; pbl[15:12] = 4'h5; pbh[3:0] = 4'h5; pal[7:0] = 8'h55; step;
      for (int i = 0; i < 5; i++)
        chk(pd[i], {1'b0, ~v[0]});
      pah[15:12] = INP; pbl[15:12] = INP; pbh[3:0] = INP; pal[7:0] = 8'h44; ext = {5{v[0]}}; step;
      chk(gin, {5{v[0]}}); done("gpio");
    end
    end_sim;
  end
endmodule // tb_top
